// >>> rtl/relay_ind_cfg.svh
`ifndef RELAY_IND_CFG_SVH
`define RELAY_IND_CFG_SVH

// Register byte offsets
`define OFS_SWITCH 12'h000
`define OFS_MODE 12'h004
`define OFS_CMD 12'h008
`define OFS_MAXCUR 12'h00c
`define OFS_LASTCUR 12'h010
`define OFS_COUNTS 12'h014
`define OFS_DUR 12'h018
`define OFS_STATUS 12'h01c
`define OFS_DISPLAY 12'h020

// Reset values
`define MODE_DEFAULT 4'ha
`define BUTTON_DEFAULT 8'h00
`define MAIN_DEFAULT 8'h00
`define ROUTE_DEFAULT 8'h00

// Mode weights
`define W_LOW_START 0
`define W_LOW_TRIP 1
`define W_HIGH_START 2
`define W_HIGH_TRIP 3

// Field positions in main setting switches
`define MAIN_RANGE_LO 6
`define MAIN_RANGE_HI 7

// Limits
`define COUNT_MAX 8'hff
`define PCT_FULL 7'h64

// Display scan: 10 us per frame at 200 MHz, fast enough to watch
`define SCAN_TIME_NS 10000
`define CLK_PERIOD_NS 5
`define SCAN_CYCLES (`SCAN_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/relay_ind_pkg.sv
package relay_ind_pkg;

  // Delay range of the high-set stage
  typedef enum logic [1:0] {
    RANGE_SHORT,
    RANGE_MID,
    RANGE_LONG
  } delay_range_type;

  // Stage events from the protection core
  typedef struct packed {
    logic low_start;
    logic low_trip;
    logic high_start;
    logic high_trip;
    logic [2:0] phase_hit;
  } stage_events_type;

  // Indicators toward the front panel
  typedef struct packed {
    logic low_start;
    logic low_trip;
    logic high_start;
    logic high_trip;
    logic [2:0] phase;
  } indicators_type;

  // One display frame: address digit and three value digits
  typedef struct packed {
    logic [3:0] addr;
    logic addr_red;
    logic [11:0] value;
  } display_type;

endpackage

// >>> rtl/relay_indication.sv
// Functional notes
// - Reset alone releases latches if switch three
// - Step alone releases latches if switch two
// - Two switches pick high-set delay range
// - Weighted mode word selects latching indicators
// - Mode word defaults to ten
// - Zero mode word lights no indicators
// - Only button switches one-three matter
// - Both buttons clear indicators, latches, records
// - Routing switches pick reclose starts, blockings
// - Phase current on digits, phase lamp
// - Red address digit with recorded value
// - Register one keeps maximum or trip current
// - Submenu keeps current at last trip
// - Count low-set starts up to 255
// - Count high-set starts up to 255
// - Low-set duration percent, 100 when tripped
// - High-set duration percent, 100 when tripped
// - Register zero shows blocking state code
// - Middle digit zero, remote reset shown
// - Test mode activates stage signals in any combination
// - Both buttons or command clear records
`timescale 1ns/1ps
`include "relay_ind_cfg.svh"

module relay_indication (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protection core
  input wire relay_ind_pkg::stage_events_type events,
  input wire logic [6:0] low_pct,
  input wire logic [6:0] high_pct,
  input wire logic [11:0] phase_one_current,
  input wire logic [11:0] phase_two_current,
  input wire logic [11:0] phase_three_current,
  // Front panel pins
  input wire logic step_button,
  input wire logic reset_button,
  input wire logic block_low_pin,
  input wire logic block_high_pin,
  input wire logic remote_reset_pin,
  // Outputs
  output relay_ind_pkg::indicators_type indicators,
  output logic trip_low_latched,
  output logic trip_high_latched,
  output relay_ind_pkg::delay_range_type high_delay_range,
  output logic [2:0] reclose_start_sel,
  output logic [4:0] blocking_route,
  output relay_ind_pkg::stage_events_type test_events,
  output relay_ind_pkg::display_type display
);
  import relay_ind_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync1; // First stage, pins step/reset
    logic [1:0] sync2;
    logic [2:0] sync1b; // First stage, block/remote
    logic [2:0] sync2b;
    logic [1:0] btn_prev; // For press edges
    logic [7:0] main_sw;
    delay_range_type dly_range; // Decoded from main switches
    logic [3:0] mode_word;
    logic [7:0] button_sw;
    logic [7:0] route_sw;
    logic [6:0] test_word; // Test mode selector
    indicators_type ind;
    logic lat_low;
    logic lat_high;
    logic [11:0] max_cur;
    logic [11:0] last_cur;
    logic [7:0] low_cnt;
    logic [7:0] high_cnt;
    logic [6:0] low_dur;
    logic [6:0] high_dur;
    logic low_start_d;
    logic high_start_d;
    logic [2:0] disp_reg; // Shown register 0..5
    logic [1:0] disp_phase; // Phase under display
    logic disp_rec; // Showing records
    logic [17:0] scan_cnt;
    display_type disp;
    logic awr;
    logic wr;
    logic bv;
    logic arr;
    logic rv;
    logic [11:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic aw_have;
    logic w_have;
    logic [31:0] rd;
    logic [1:0] bresp;
    logic [1:0] rresp;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Write data after byte strobes, for command register
  logic [31:0] wmerge;
  logic [11:0] cur_max; // Largest phase current now
  logic [11:0] cur_shown;

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  // One combinational pass over all state
  always_comb begin
    logic step_p;
    logic rst_p;
    logic both;
    logic clr_ind;
    logic rel_lat;
    logic erase;
    logic wr_go;
    logic map_ok;
    logic [3:0] mw;
    step_p = 1'b0;
    rst_p = 1'b0;
    both = 1'b0;
    clr_ind = 1'b0;
    rel_lat = 1'b0;
    erase = 1'b0;
    wr_go = 1'b0;
    map_ok = 1'b0;
    mw = 4'h0;
    state_next = state_reg;
    wmerge = 32'h0000_0000;
    cur_max = phase_one_current;
    if (phase_two_current > cur_max) begin
      cur_max = phase_two_current;
    end
    if (phase_three_current > cur_max) begin
      cur_max = phase_three_current;
    end
    cur_shown = phase_one_current;
    if (state_reg.disp_phase == 2'h1) begin
      cur_shown = phase_two_current;
    end else if (state_reg.disp_phase == 2'h2) begin
      cur_shown = phase_three_current;
    end

    // Pin synchronisers
    state_next.sync1 = {step_button, reset_button};
    state_next.sync2 = state_reg.sync1;
    state_next.sync1b = {block_low_pin, block_high_pin, remote_reset_pin};
    state_next.sync2b = state_reg.sync1b;
    state_next.btn_prev = state_reg.sync2;

    // Decode presses; a button joining a held one counts as both
    both = (state_reg.sync2 == 2'b11) && (state_reg.btn_prev != 2'b11);
    step_p = state_reg.sync2[1] && !state_reg.btn_prev[1] && !state_reg.sync2[0];
    rst_p = state_reg.sync2[0] && !state_reg.btn_prev[0] && !state_reg.sync2[1];

    if (both) begin
      clr_ind = 1'b1;
      rel_lat = 1'b1;
      erase = 1'b1;
    end
    if (step_p && state_reg.button_sw[0]) begin
      clr_ind = 1'b1;
    end
    if (step_p && state_reg.button_sw[1]) begin
      clr_ind = 1'b1;
      rel_lat = 1'b1;
    end
    // Reset alone clears lamps in every setting
    if (rst_p) begin
      clr_ind = 1'b1;
    end
    if (rst_p && state_reg.button_sw[2]) begin
      rel_lat = 1'b1;
    end

    // Step walks the record menu when button switches one and two are both off
    if (step_p && state_reg.button_sw[1:0] == 2'b00) begin
      state_next.disp_rec = 1'b1;
      state_next.disp_reg = (state_reg.disp_reg == 3'h5) ? 3'h0 : state_reg.disp_reg + 3'h1;
    end

    //--------------------------------------------------------------
    // AXI4-Lite write
    //--------------------------------------------------------------
    if (s_axi_awvalid && state_reg.awr) begin
      state_next.awa = s_axi_awaddr;
      state_next.aw_have = 1'b1;
      state_next.awr = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wr) begin
      state_next.wd = s_axi_wdata;
      state_next.ws = s_axi_wstrb;
      state_next.w_have = 1'b1;
      state_next.wr = 1'b0;
    end
    wr_go = state_reg.aw_have && state_reg.w_have && !state_reg.bv;
    if (wr_go) begin
      map_ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
        wmerge[8*i +: 8] = state_reg.ws[i] ? state_reg.wd[8*i +: 8] : 8'h00;
      end
      unique case (state_reg.awa)
        `OFS_SWITCH: begin
          if (state_reg.ws[0]) state_next.main_sw = state_reg.wd[7:0];
          // One switch mid range, both long
          if (state_reg.ws[0]) state_next.dly_range = delay_range_type'(
            {1'b0, state_reg.wd[`MAIN_RANGE_LO]} + {1'b0, state_reg.wd[`MAIN_RANGE_HI]});
          if (state_reg.ws[1]) state_next.button_sw = {5'h00, state_reg.wd[10:8]};
          if (state_reg.ws[2]) state_next.route_sw = state_reg.wd[23:16];
        end
        `OFS_MODE: begin
          if (state_reg.ws[0]) state_next.mode_word = state_reg.wd[3:0];
        end
        `OFS_CMD: begin
          erase = erase | wmerge[0];
          rel_lat = rel_lat | wmerge[1];
          clr_ind = clr_ind | wmerge[1];
          if (state_reg.ws[1]) state_next.test_word = state_reg.wd[14:8];
        end
        `OFS_DISPLAY: begin
          if (state_reg.ws[0]) begin
            state_next.disp_rec = state_reg.wd[0];
            state_next.disp_reg = (state_reg.wd[3:1] > 3'h5) ? 3'h0 : state_reg.wd[3:1];
            state_next.disp_phase = (state_reg.wd[5:4] == 2'h3) ? 2'h0 : state_reg.wd[5:4];
          end
        end
        default: map_ok = 1'b0;
      endcase
      state_next.bresp = map_ok ? 2'b00 : 2'b10;
      state_next.bv = 1'b1;
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
    end
    if (state_reg.bv && s_axi_bready) begin
      state_next.bv = 1'b0;
      state_next.awr = 1'b1;
      state_next.wr = 1'b1;
    end

    //--------------------------------------------------------------
    // Indicators and latches
    //--------------------------------------------------------------
    mw = state_reg.mode_word;
    if (clr_ind) begin
      state_next.ind = '0;
    end
    if (rel_lat) begin
      state_next.lat_low = 1'b0;
      state_next.lat_high = 1'b0;
    end
    state_next.ind.low_start = (mw != 4'h0) && (events.low_start ||
      (mw[`W_LOW_START] && state_next.ind.low_start));
    state_next.ind.low_trip = (mw != 4'h0) && (events.low_trip ||
      (mw[`W_LOW_TRIP] && state_next.ind.low_trip));
    state_next.ind.high_start = (mw != 4'h0) && (events.high_start ||
      (mw[`W_HIGH_START] && state_next.ind.high_start));
    state_next.ind.high_trip = (mw != 4'h0) && (events.high_trip ||
      (mw[`W_HIGH_TRIP] && state_next.ind.high_trip));
    state_next.ind.phase = (mw == 4'h0) ? 3'h0 : (state_next.ind.phase | events.phase_hit);
    // Trip outputs latch until released
    state_next.lat_low = state_next.lat_low | events.low_trip;
    state_next.lat_high = state_next.lat_high | events.high_trip;

    //--------------------------------------------------------------
    // Recorded values
    //--------------------------------------------------------------
    state_next.low_start_d = events.low_start;
    state_next.high_start_d = events.high_start;
    if (erase) begin
      state_next.max_cur = 12'h000;
      state_next.last_cur = 12'h000;
      state_next.low_cnt = 8'h00;
      state_next.high_cnt = 8'h00;
      state_next.low_dur = 7'h00;
      state_next.high_dur = 7'h00;
    end else begin
      if ((events.low_trip || events.high_trip) || cur_max > state_reg.max_cur) begin
        state_next.max_cur = cur_max;
      end
      if (events.low_trip || events.high_trip) begin
        state_next.last_cur = cur_max;
      end
      if (events.low_start && !state_reg.low_start_d && state_reg.low_cnt != `COUNT_MAX) begin
        state_next.low_cnt = state_reg.low_cnt + 8'h01;
      end
      if (events.high_start && !state_reg.high_start_d && state_reg.high_cnt != `COUNT_MAX) begin
        state_next.high_cnt = state_reg.high_cnt + 8'h01;
      end
      if (events.low_start && !state_reg.low_start_d) begin
        state_next.low_dur = 7'h00;
      end else if (events.low_trip) begin
        state_next.low_dur = `PCT_FULL;
      end else if (events.low_start) begin
        state_next.low_dur = (low_pct > `PCT_FULL) ? `PCT_FULL : low_pct;
      end
      if (events.high_start && !state_reg.high_start_d) begin
        state_next.high_dur = 7'h00;
      end else if (events.high_trip) begin
        state_next.high_dur = `PCT_FULL;
      end else if (events.high_start) begin
        state_next.high_dur = (high_pct > `PCT_FULL) ? `PCT_FULL : high_pct;
      end
    end

    //--------------------------------------------------------------
    // Display frame, refreshed once per scan period
    //--------------------------------------------------------------
    state_next.scan_cnt = state_reg.scan_cnt + 18'h00001;
    if (state_reg.scan_cnt == 18'(`SCAN_CYCLES - 1)) begin
      state_next.scan_cnt = 18'h00000;
      if (state_reg.disp_rec) begin
        state_next.disp.addr = {1'b0, state_reg.disp_reg};
        state_next.disp.addr_red = 1'b1;
        unique case (state_reg.disp_reg)
          3'h1: state_next.disp.value = state_reg.max_cur;
          3'h2: state_next.disp.value = {4'h0, state_reg.low_cnt};
          3'h3: state_next.disp.value = {4'h0, state_reg.high_cnt};
          3'h4: state_next.disp.value = {5'h00, state_reg.low_dur};
          3'h5: state_next.disp.value = {5'h00, state_reg.high_dur};
          default: state_next.disp.value = {2'b00, state_reg.sync2b[1], state_reg.sync2b[2],
            4'h0, 3'h0, state_reg.sync2b[0]};
        endcase
      end else begin
        state_next.disp.addr = 4'h0;
        state_next.disp.addr_red = 1'b0;
        state_next.disp.value = cur_shown;
      end
    end

    //--------------------------------------------------------------
    // AXI4-Lite read
    //--------------------------------------------------------------
    if (s_axi_arvalid && state_reg.arr) begin
      state_next.arr = 1'b0;
      state_next.rv = 1'b1;
      state_next.rresp = 2'b00;
      unique case (s_axi_araddr)
        `OFS_SWITCH: state_next.rd = {8'h00, state_reg.route_sw, state_reg.button_sw,
          state_reg.main_sw};
        `OFS_MODE: state_next.rd = {28'h0000000, state_reg.mode_word};
        `OFS_CMD: state_next.rd = {17'h00000, state_reg.test_word, 8'h00};
        `OFS_MAXCUR: state_next.rd = {20'h00000, state_reg.max_cur};
        `OFS_LASTCUR: state_next.rd = {20'h00000, state_reg.last_cur};
        `OFS_COUNTS: state_next.rd = {16'h0000, state_reg.high_cnt, state_reg.low_cnt};
        `OFS_DUR: state_next.rd = {17'h00000, state_reg.high_dur, 1'b0, state_reg.low_dur};
        `OFS_STATUS: state_next.rd = {23'h000000, state_reg.lat_high, state_reg.lat_low,
          state_reg.sync2b, state_reg.ind.low_start, state_reg.ind.low_trip,
          state_reg.ind.high_start, state_reg.ind.high_trip};
        `OFS_DISPLAY: state_next.rd = {26'h0000000, state_reg.disp_phase,
          state_reg.disp_reg, state_reg.disp_rec};
        default: begin
          state_next.rd = 32'h0000_0000;
          state_next.rresp = 2'b10;
        end
      endcase
    end
    if (state_reg.rv && s_axi_rready) begin
      state_next.rv = 1'b0;
      state_next.arr = 1'b1;
    end
  end

  //----------------------------------------------------------------
  // Register stage
  //----------------------------------------------------------------
  // Synchronous reset; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.mode_word <= `MODE_DEFAULT;
      state_reg.button_sw <= `BUTTON_DEFAULT;
      state_reg.main_sw <= `MAIN_DEFAULT;
      state_reg.route_sw <= `ROUTE_DEFAULT;
      state_reg.awr <= 1'b1;
      state_reg.wr <= 1'b1;
      state_reg.arr <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  //----------------------------------------------------------------
  // Outputs, all straight from state
  //----------------------------------------------------------------
  assign s_axi_awready = state_reg.awr;
  assign s_axi_wready = state_reg.wr;
  assign s_axi_bvalid = state_reg.bv;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arr;
  assign s_axi_rvalid = state_reg.rv;
  assign s_axi_rdata = state_reg.rd;
  assign s_axi_rresp = state_reg.rresp;
  assign indicators = state_reg.ind;
  assign trip_low_latched = state_reg.lat_low;
  assign trip_high_latched = state_reg.lat_high;
  assign display = state_reg.disp;
  // Delay range kept in a flop
  assign high_delay_range = state_reg.dly_range;
  assign reclose_start_sel = state_reg.route_sw[2:0];
  assign blocking_route = state_reg.route_sw[7:3];
  // Test word drives stage signals bit for bit, any combination at once
  assign test_events = state_reg.test_word;

endmodule

// >>> verification/panel_model.sv
`timescale 1ns/1ps
// ---------------------------
// Front panel and pins
// ---------------------------
module panel_model (
  input wire logic aclk,
  input wire relay_ind_pkg::indicators_type indicators,
  input wire relay_ind_pkg::display_type display,
  output logic step_button,
  output logic reset_button,
  output logic block_low_pin,
  output logic block_high_pin,
  output logic remote_reset_pin
);
  import relay_ind_pkg::*;
  // Keys released, pins idle
  initial begin
    step_button = 1'b0;
    reset_button = 1'b0;
    {block_low_pin, block_high_pin, remote_reset_pin} = 3'b000;
  end
  // Held ten cycles so the synchroniser sees a clean press
  task automatic press(input logic s, input logic r);
    step_button <= s;
    reset_button <= r;
    repeat (10) @(posedge aclk);
    step_button <= 1'b0;
    reset_button <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask
  // Blocking and remote reset levels
  task automatic pins(input logic [2:0] v);
    {block_low_pin, block_high_pin, remote_reset_pin} <= v;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// >>> verification/relay_ind_props.sv
`timescale 1ns/1ps
// ---------------------------
// Port checker
// ---------------------------
module relay_ind_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire relay_ind_pkg::stage_events_type events,
  input wire logic step_button,
  input wire logic reset_button,
  input wire relay_ind_pkg::indicators_type indicators,
  input wire logic trip_low_latched,
  input wire logic trip_high_latched,
  input wire relay_ind_pkg::delay_range_type high_delay_range,
  input wire logic [2:0] reclose_start_sel,
  input wire logic [4:0] blocking_route,
  input wire relay_ind_pkg::stage_events_type test_events
);
  import relay_ind_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Full-word write taken in one edge
  logic wr_hit, sw_hit, tw_hit;
  logic [31:0] sw_q; // Last switch word
  logic [6:0] tw_q; // Last test word
  delay_range_type exp_rng;
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign sw_hit = wr_hit && s_axi_wstrb == 4'hf && s_axi_awaddr == 12'h000;
  assign tw_hit = wr_hit && s_axi_wstrb == 4'hf && s_axi_awaddr == 12'h008;
  assign exp_rng = (sw_q[7:6] == 2'b00) ? RANGE_SHORT :
    ((sw_q[7:6] == 2'b11) ? RANGE_LONG : RANGE_MID);
  // Shadow of written words; split takes are not tracked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= 32'h0;
      tw_q <= 7'h0;
    end else begin
      if (sw_hit) begin
        sw_q <= s_axi_wdata;
      end
      if (tw_hit) begin
        tw_q <= s_axi_wdata[14:8];
      end
    end
  end
  // ---------------------------
  // Properties
  // ---------------------------
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready high while busy");
  ar_busy_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##0 s_axi_rvalid)
    else $error("read answer late");
  b_time_a: assert property (wr_hit |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  range_decode_a: assert property (sw_hit |-> ##3 high_delay_range == exp_rng)
    else $error("delay range mismatch");
  route_fields_a: assert property (sw_hit |-> ##3 {blocking_route, reclose_start_sel} == sw_q[23:16])
    else $error("routing mismatch");
  test_word_a: assert property (tw_hit |-> ##3 test_events == tw_q)
    else $error("test word mismatch");
  both_keys_a: assert property ((step_button && reset_button && !events.low_trip &&
    !events.high_trip) [*6] |-> !trip_low_latched && !trip_high_latched &&
    !indicators.low_trip && !indicators.high_trip) else $error("both keys kept latch");
endmodule
bind relay_indication relay_ind_props chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .events,
  .step_button, .reset_button, .indicators, .trip_low_latched, .trip_high_latched,
  .high_delay_range, .reclose_start_sel, .blocking_route, .test_events);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
// ---------------------------
// Bench top
// ---------------------------
module tb_top;
  import relay_ind_pkg::*;
  logic aclk, aresetn, clk_en;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, er;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  stage_events_type events, test_events;
  logic [6:0] low_pct, high_pct;
  logic [11:0] phase_one_current, phase_two_current, phase_three_current;
  logic step_button, reset_button, block_low_pin, block_high_pin, remote_reset_pin;
  indicators_type indicators;
  logic trip_low_latched, trip_high_latched;
  delay_range_type high_delay_range;
  logic [2:0] reclose_start_sel;
  logic [4:0] blocking_route;
  logic [7:0] rt;
  display_type display;
  int bad_count, samples_checked;
  relay_indication dut_u (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events, .low_pct, .high_pct,
    .phase_one_current, .phase_two_current, .phase_three_current, .step_button, .reset_button,
    .block_low_pin, .block_high_pin, .remote_reset_pin, .indicators, .trip_low_latched,
    .trip_high_latched, .high_delay_range, .reclose_start_sel, .blocking_route, .test_events,
    .display);
  panel_model panel_u (.aclk, .indicators, .display, .step_button, .reset_button,
    .block_low_pin, .block_high_pin, .remote_reset_pin);
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ---------------------------
  // Tasks
  // ---------------------------
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  // Masked register compare
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_data & m, e);
  endtask
  task automatic ev(input logic [6:0] v, input int n);
    events <= v;
    repeat (n) @(posedge aclk);
  endtask
  // Low-set start and trip on phase one, then clear
  task automatic fault();
    ev(7'h61, 6);
    ev(7'h00, 6);
  endtask
  // ---------------------------
  // Tests
  // ---------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {clk_en, s_axi_bready, s_axi_rready} = 3'b111; // Always ready, never frozen
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    events = 7'h00;
    low_pct = 7'h32;
    high_pct = 7'h25;
    phase_one_current = 12'h123;
    phase_two_current = 12'h234;
    phase_three_current = 12'h0ff;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h004, 32'hf, 32'ha);
    rc(12'h000, 32'h700, 32'h0);
    rd(12'h100);
    chk({30'h0, rd_resp}, 32'h2);
    for (int k = 0; k < 4; k++) begin
      rt = 8'h5a ^ {4{k[1:0]}};
      er = (k == 0) ? RANGE_SHORT : ((k == 3) ? RANGE_LONG : RANGE_MID);
      wr(12'h000, {8'h00, rt, 8'h00, k[1:0], 6'h00});
      chk({30'h0, high_delay_range}, {30'h0, er});
      chk({24'h0, blocking_route, reclose_start_sel}, {24'h0, rt});
    end
    // Step alone releases the latch when switch two is set
    wr(12'h000, 32'h0000_0208);
    fault();
    chk({28'h0, indicators[6:3]}, 32'h4);
    panel_u.press(1'b1, 1'b0);
    chk({31'h0, trip_low_latched}, 32'h0);
    rc(12'h00c, 32'hfff, 32'h234);
    rc(12'h010, 32'hfff, 32'h234);
    // Reset alone releases the latch when switch three is set
    wr(12'h000, 32'h0000_0408);
    fault();
    panel_u.press(1'b0, 1'b1);
    chk({31'h0, trip_low_latched}, 32'h0);
    rc(12'h014, 32'hff, 32'h2);
    rc(12'h018, 32'h7f, 32'h64);
    // Upper button switches have no effect
    wr(12'h000, 32'h0000_f808);
    fault();
    panel_u.press(1'b1, 1'b0);
    chk({31'h0, trip_low_latched}, 32'h1);
    {phase_one_current, phase_two_current, phase_three_current} <= 36'h0; // No load
    panel_u.press(1'b1, 1'b1);
    chk({30'h0, trip_low_latched, indicators.low_trip}, 32'h0);
    rc(12'h00c, 32'hfff, 32'h0);
    rc(12'h014, 32'hffff, 32'h0);
    ev(7'h10, 4);
    ev(7'h00, 4);
    rc(12'h018, 32'h7f00, 32'h2500);
    repeat (256) begin
      ev(7'h10, 2);
      ev(7'h00, 2);
    end
    rc(12'h014, 32'hff00, 32'hff00);
    wr(12'h008, 32'h0000_0001);
    rc(12'h014, 32'hffff, 32'h0);
    wr(12'h004, 32'h0);
    fault();
    chk({25'h0, indicators}, 32'h0);
    wr(12'h008, 32'h0000_5500);
    chk({25'h0, test_events}, 32'h55);
    panel_u.pins(3'b101);
    rc(12'h01c, 32'h1f0, 32'hd0);
    wr(12'h020, 32'h0000_0001);
    repeat (2010) @(posedge aclk);
    chk({15'h0, display}, 32'h1101);
    phase_two_current <= 12'h345;
    wr(12'h020, 32'h0000_0010);
    repeat (2010) @(posedge aclk);
    chk({15'h0, display}, 32'h0345);
    complete_run();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule
